// ==== core/filter_cfg_pkg.sv ====
// constants, types and helpers shared by the serial configuration block
package filter_cfg_pkg;

	// ---------------------------------------------------------------
	// control word layout
	// ---------------------------------------------------------------
	localparam int         WORD_BITS  = 16;   // bits per control word
	localparam int         ADDR_HI    = 10;   // register select, high bit
	localparam int         ADDR_LO    = 9;    // register select, low bit
	localparam int         LOAD_BIT   = 8;    // apply bit of gain words
	localparam int         CODE_HI    = 7;    // top bit of a gain code

	// register select codes
	typedef enum logic [1:0] {
		SEL_LEFT  = 2'b00,                    // left gain word
		SEL_RIGHT = 2'b01,                    // right gain word
		SEL_FUNC  = 2'b10,                    // function word
		SEL_FMT   = 2'b11                     // format word
	} reg_sel_t;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int FN_SILENCE_OFF = 0;        // soft mute off when set
	localparam int FN_EMPHASIS    = 1;        // de-emphasis on
	localparam int FN_HALVED      = 2;        // four-times oversampling
	localparam int FN_IN_LO       = 3;        // input code, two bits
	localparam int FN_OUT_LO      = 5;        // output length, two bits
	localparam int FMT_I2S        = 0;        // frame format bit
	localparam int FMT_POLARITY   = 1;        // frame side polarity
	localparam int FMT_SHARED     = 2;        // shared gain select
	localparam int FMT_ROLLOFF    = 3;        // slow roll-off select
	localparam int FMT_CLK_HALF   = 5;        // clock out divided by two
	localparam int FMT_RATE_LO    = 6;        // de-emphasis rate, two bits

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] LEFT_RST  = 16'h00FF;  // 0 dB, no apply
	localparam logic [15:0] RIGHT_RST = 16'h02FF;  // 0 dB, no apply
	localparam logic [15:0] FUNC_RST  = 16'h0400;  // soft mute on
	localparam logic [15:0] FMT_RST   = 16'h0600;  // all options clear
	localparam logic        STROBE_RST = 1'b1;     // strobe seen idle high

	// ---------------------------------------------------------------
	// codes and word lengths
	// ---------------------------------------------------------------
	localparam logic [7:0] CODE_FULL_SCALE = 8'hFF;  // 0 dB
	localparam logic [7:0] CODE_SILENT     = 8'h00;  // channel muted
	localparam logic [1:0] RATE_RESERVED   = 2'h1;   // unused rate code
	localparam logic [4:0] BITS_NONE = 5'h00;        // reserved format
	localparam logic [4:0] BITS_16   = 5'h10;
	localparam logic [4:0] BITS_18   = 5'h12;
	localparam logic [4:0] BITS_20   = 5'h14;
	localparam logic [4:0] BITS_24   = 5'h18;

	// attenuation in half-dB steps below full scale for a gain code
	function automatic logic [7:0] atten_half_db(input logic [7:0] code);
		return CODE_FULL_SCALE - code;
	endfunction

endpackage

// ==== core/ctl_link_if.sv ====
// internal link between the shifter, the decoder and the register core
`timescale 1ns/1ns
`default_nettype none
interface ctl_link_if;
	logic [15:0] word;          // last committed control word
	logic        commit;        // one-cycle pulse, word is new
	logic [7:0]  fn_bits;       // low byte of the function word
	logic [7:0]  fmt_bits;      // low byte of the format word
	logic [4:0]  in_bits;       // decoded input word length
	logic [4:0]  out_bits;      // decoded output word length
	logic        in_left_just;  // input is left-justified
	logic        in_reserved;   // input code is reserved
	logic        rate_reserved; // de-emphasis rate code is reserved
	logic        left_on_high;  // left channel on frame clock high

	modport shifter (output word, commit);
	modport decoder (input fn_bits, fmt_bits,
		output in_bits, out_bits, in_left_just, in_reserved,
		rate_reserved, left_on_high);
	modport core (input word, commit, in_bits, out_bits, in_left_just,
		in_reserved, rate_reserved, left_on_high,
		output fn_bits, fmt_bits);
endinterface
`default_nettype wire

// ==== core/serial_word_shifter.sv ====
// three-wire serial port receiver: shifts words in, commits on strobe
`timescale 1ns/1ns
`default_nettype none
module serial_word_shifter
	import filter_cfg_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          strobe,
	input  wire logic          sclk,
	input  wire logic          sdata,
	ctl_link_if.shifter        link
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic                 sclk_q;   // previous shift clock level
		logic                 strobe_q; // previous strobe level
		logic [WORD_BITS-1:0] shift;    // bits gathered so far
		logic [WORD_BITS-1:0] word;     // committed word
		logic                 commit;   // commit pulse
	} shift_state_t;

	shift_state_t r;
	shift_state_t next_r;

	// shift on clock rise while strobe low, commit on strobe rise
	always_comb begin
		next_r          = r;
		next_r.commit   = 1'b0;
		next_r.sclk_q   = sclk;
		next_r.strobe_q = strobe;
		if (sclk && !r.sclk_q && !strobe) begin
			next_r.shift = {r.shift[WORD_BITS-2:0], sdata};
		end
		if (strobe && !r.strobe_q) begin
			next_r.commit = 1'b1;
			next_r.word   = r.shift;
		end
	end

	// register the state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r          <= '0;
			r.strobe_q <= STROBE_RST;
		end else begin
			r <= next_r;
		end
	end

	assign link.word   = r.word;
	assign link.commit = r.commit;

	a_shift_msb_first: assert property (@(posedge clk) disable iff (!resetn)
		(sclk && !r.sclk_q && !strobe) |=>
		r.shift == {$past(r.shift[WORD_BITS-2:0]), $past(sdata)})
		else $error("shift register did not take the data bit");
	a_commit_on_rise: assert property (@(posedge clk) disable iff (!resetn)
		(strobe && !r.strobe_q) |=> link.commit && link.word == $past(r.shift))
		else $error("strobe rise did not commit the word");
	a_shift_frozen: assert property (@(posedge clk) disable iff (!resetn)
		strobe |=> r.shift == $past(r.shift))
		else $error("bits shifted while strobe was high");
endmodule // serial_word_shifter
`default_nettype wire

// ==== core/config_decode.sv ====
// decodes format fields into word lengths and flags
`timescale 1ns/1ns
`default_nettype none
module config_decode
	import filter_cfg_pkg::*;
(
	ctl_link_if.decoder link
);
	// input format from frame-format bit and input code
	always_comb begin
		link.in_left_just = 1'b0;
		link.in_reserved  = 1'b0;
		unique case ({link.fmt_bits[FMT_I2S],
			link.fn_bits[FN_IN_LO+1:FN_IN_LO]})
			3'b000: link.in_bits = BITS_16;
			3'b001: link.in_bits = BITS_20;
			3'b010: link.in_bits = BITS_24;
			3'b011: begin
				link.in_bits      = BITS_24;
				link.in_left_just = 1'b1;
			end
			3'b100: link.in_bits = BITS_16;
			3'b101: link.in_bits = BITS_24;
			3'b110, 3'b111: begin
				link.in_bits     = BITS_NONE;
				link.in_reserved = 1'b1;
			end
		endcase
	end

	// output word length, always MSB first
	always_comb begin
		unique case (link.fn_bits[FN_OUT_LO+1:FN_OUT_LO])
			2'b00: link.out_bits = BITS_16;
			2'b01: link.out_bits = BITS_18;
			2'b10: link.out_bits = BITS_20;
			2'b11: link.out_bits = BITS_24;
		endcase
	end

	// frame polarity and rate code checks
	assign link.left_on_high  = !link.fmt_bits[FMT_POLARITY];
	assign link.rate_reserved =
		link.fmt_bits[FMT_RATE_LO+1:FMT_RATE_LO] == RATE_RESERVED;
endmodule // config_decode
`default_nettype wire

// ==== core/filter_serial_config_registers.sv ====
// software-mode configuration registers of the interpolation filter
//
// What this block does
// - mode pin high enables serial register control
// - sixteen-bit words arrive MSB first
// - bits B10:B9 choose one of four registers
// - gain words: apply bit B8, code B7:B0
// - sharing on: left code feeds both channels
// - sharing off: each channel uses own code
// - attenuation is half dB per step, 00 mutes
// - left apply sets both channel levels
// - left write without apply keeps level
// - right apply sets both channel levels
// - right write without apply keeps level
// - soft mute bit: 0 on, 1 off
// - de-emphasis bit: 0 off, 1 on
// - oversampling bit: 0 eight-times, 1 four-times
// - frame bit plus code choose input format
// - output codes 00,01,10 give 16,18,20 bits
// - format word bit positions fixed
// - output code 11 gives 24 bits
// - polarity bit: 0 left on high
// - rate code: 44.1, reserved, 48, 32 kHz
`timescale 1ns/1ns
`default_nettype none
module filter_serial_config_registers
	import filter_cfg_pkg::*;
(
	input  wire logic       clk,                   // system clock
	input  wire logic       resetn,                // async reset, low
	input  wire logic       mode_pin,              // high: software mode
	input  wire logic       latch_strobe_pin,      // word latch strobe
	input  wire logic       serial_shift_clock_pin,// bit clock
	input  wire logic       serial_input_pin,      // serial data
	output var  logic [7:0] left_applied_code,     // left level in use
	output var  logic [7:0] right_applied_code,    // right level in use
	output var  logic [7:0] left_atten_half_db,    // left attenuation
	output var  logic [7:0] right_atten_half_db,   // right attenuation
	output var  logic       left_full_mute,        // left code is 00
	output var  logic       right_full_mute,       // right code is 00
	output var  logic       soft_silence_off,      // soft mute released
	output var  logic       emphasis_undo_on,      // de-emphasis on
	output var  logic       halved_oversample_sel, // four-times mode
	output var  logic [1:0] input_format_code,     // raw input code
	output var  logic       frame_format_i2s,      // frame format bit
	output var  logic [4:0] input_word_bits,       // input word length
	output var  logic       input_left_justified,  // left-justified
	output var  logic       input_format_reserved, // illegal input code
	output var  logic [1:0] output_length_code,    // raw output code
	output var  logic [4:0] output_word_bits,      // output word length
	output var  logic       frame_side_polarity,   // raw polarity bit
	output var  logic       left_on_frame_high,    // left on clock high
	output var  logic       shared_gain_select,    // shared gain on
	output var  logic       slow_rolloff_sel,      // slow roll-off
	output var  logic       clock_out_half,        // clock out halved
	output var  logic [1:0] emphasis_rate_code,    // raw rate code
	output var  logic       emphasis_rate_reserved // illegal rate code
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] left_gain_reg;   // last left gain word
		logic [15:0] right_gain_reg;  // last right gain word
		logic [15:0] function_reg;    // function word
		logic [15:0] format_reg;      // format word
		logic [7:0]  left_level;      // applied left code
		logic [7:0]  right_level;     // applied right code
		logic [7:0]  left_atten;      // left attenuation, half dB
		logic [7:0]  right_atten;     // right attenuation, half dB
		logic        left_mute;       // left fully muted
		logic        right_mute;      // right fully muted
		logic [4:0]  in_bits;         // input word length
		logic [4:0]  out_bits;        // output word length
		logic        in_left_just;    // input left-justified
		logic        in_reserved;     // input code reserved
		logic        rate_reserved;   // rate code reserved
		logic        left_on_high;    // left on frame clock high
	} core_state_t;

	core_state_t r;                   // registered state
	core_state_t next_r;              // next state

	// ---------------------------------------------------------------
	// serial port and field decode
	// ---------------------------------------------------------------
	ctl_link_if link ();

	// gathers bits and raises a commit pulse per word
	serial_word_shifter serial_word_shifter_i (
		.clk    (clk),
		.resetn (resetn),
		.strobe (latch_strobe_pin),
		.sclk   (serial_shift_clock_pin),
		.sdata  (serial_input_pin),
		.link   (link)
	);

	// turns stored fields into word lengths and flags
	config_decode config_decode_i (
		.link (link)
	);

	// decoder looks at the stored low bytes only
	assign link.fn_bits  = r.function_reg[7:0];
	assign link.fmt_bits = r.format_reg[7:0];

	// ---------------------------------------------------------------
	// write decode
	// ---------------------------------------------------------------
	logic        wr_any;     // accepted word this cycle
	logic        wr_left;    // left gain word accepted
	logic        wr_right;   // right gain word accepted
	logic        wr_load;    // apply bit of the accepted word
	logic        shared;     // shared gain currently selected
	logic [7:0]  wr_code;    // gain code of the accepted word

	// words only count in software mode
	assign wr_any   = mode_pin && link.commit;
	assign wr_left  = wr_any &&
		link.word[ADDR_HI:ADDR_LO] == SEL_LEFT;
	assign wr_right = wr_any &&
		link.word[ADDR_HI:ADDR_LO] == SEL_RIGHT;
	assign wr_load  = link.word[LOAD_BIT];
	assign wr_code  = link.word[CODE_HI:0];
	assign shared   = r.format_reg[FMT_SHARED];

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// the reserved bits are kept as written but steer nothing
	always_comb begin
		next_r = r;
		// register writes, one word per commit
		if (wr_any) begin
			unique case (reg_sel_t'(link.word[ADDR_HI:ADDR_LO]))
				SEL_LEFT: begin
					next_r.left_gain_reg = link.word;
					// apply: left from new code, right from choice
					if (wr_load) begin
						next_r.left_level  = wr_code;
						next_r.right_level = shared ?
							wr_code : r.right_gain_reg[CODE_HI:0];
					end
					// no apply: code stored, level held
				end
				SEL_RIGHT: begin
					next_r.right_gain_reg = link.word;
					// apply: right from choice, left from stored
					if (wr_load) begin
						next_r.right_level = shared ?
							r.left_gain_reg[CODE_HI:0] : wr_code;
						next_r.left_level  =
							r.left_gain_reg[CODE_HI:0];
					end
					// no apply: code stored, level held
				end
				SEL_FUNC: begin
					next_r.function_reg = link.word;
				end
				SEL_FMT: begin
					next_r.format_reg = link.word;
				end
			endcase
		end
		// attenuation and hard mute follow the applied codes
		next_r.left_atten    = atten_half_db(r.left_level);
		next_r.right_atten   = atten_half_db(r.right_level);
		next_r.left_mute     = r.left_level == CODE_SILENT;
		next_r.right_mute    = r.right_level == CODE_SILENT;
		// decoded formats are held in flops for clean outputs
		next_r.in_bits       = link.in_bits;
		next_r.out_bits      = link.out_bits;
		next_r.in_left_just  = link.in_left_just;
		next_r.in_reserved   = link.in_reserved;
		next_r.rate_reserved = link.rate_reserved;
		next_r.left_on_high  = link.left_on_high;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// registers keep their words until the next write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r                <= '0;
			r.left_gain_reg  <= LEFT_RST;
			r.right_gain_reg <= RIGHT_RST;
			r.function_reg   <= FUNC_RST;
			r.format_reg     <= FMT_RST;
			r.left_level     <= CODE_FULL_SCALE;
			r.right_level    <= CODE_FULL_SCALE;
			r.in_bits        <= BITS_16;
			r.out_bits       <= BITS_16;
			r.left_on_high   <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from flops
	// ---------------------------------------------------------------
	assign left_applied_code      = r.left_level;
	assign right_applied_code     = r.right_level;
	assign left_atten_half_db     = r.left_atten;
	assign right_atten_half_db    = r.right_atten;
	assign left_full_mute         = r.left_mute;
	assign right_full_mute        = r.right_mute;
	assign soft_silence_off       = r.function_reg[FN_SILENCE_OFF];
	assign emphasis_undo_on       = r.function_reg[FN_EMPHASIS];
	assign halved_oversample_sel  = r.function_reg[FN_HALVED];
	assign input_format_code      =
		r.function_reg[FN_IN_LO+1:FN_IN_LO];
	assign frame_format_i2s       = r.format_reg[FMT_I2S];
	assign input_word_bits        = r.in_bits;
	assign input_left_justified   = r.in_left_just;
	assign input_format_reserved  = r.in_reserved;
	assign output_length_code     =
		r.function_reg[FN_OUT_LO+1:FN_OUT_LO];
	assign output_word_bits       = r.out_bits;
	assign frame_side_polarity    = r.format_reg[FMT_POLARITY];
	assign left_on_frame_high     = r.left_on_high;
	assign shared_gain_select     = r.format_reg[FMT_SHARED];
	assign slow_rolloff_sel       = r.format_reg[FMT_ROLLOFF];
	assign clock_out_half         = r.format_reg[FMT_CLK_HALF];
	assign emphasis_rate_code     =
		r.format_reg[FMT_RATE_LO+1:FMT_RATE_LO];
	assign emphasis_rate_reserved = r.rate_reserved;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_mode_gate: assert property (
		!mode_pin |=> $stable(r.left_gain_reg) && $stable(r.right_gain_reg)
		&& $stable(r.function_reg) && $stable(r.format_reg))
		else $error("register changed outside software mode");
	a_reg_select: assert property (
		wr_any && link.word[ADDR_HI:ADDR_LO] == SEL_FUNC |=>
		r.function_reg == $past(link.word) && $stable(r.format_reg))
		else $error("function word went to the wrong register");
	a_left_apply: assert property (
		wr_left && wr_load |=> left_applied_code == $past(wr_code))
		else $error("left apply did not set the left level");
	a_left_hold: assert property (
		wr_left && !wr_load |=> $stable(left_applied_code)
		&& $stable(right_applied_code))
		else $error("left write without apply moved a level");
	a_right_apply: assert property (
		wr_right && wr_load && !shared |=>
		right_applied_code == $past(wr_code) &&
		left_applied_code == $past(r.left_gain_reg[CODE_HI:0]))
		else $error("right apply set the wrong levels");
	a_right_hold: assert property (
		wr_right && !wr_load |=> $stable(right_applied_code))
		else $error("right write without apply moved the level");
	a_shared_gain: assert property (
		(wr_left || wr_right) && wr_load && shared |=>
		right_applied_code == left_applied_code)
		else $error("shared gain did not copy the left code");
	a_split_gain: assert property (
		wr_left && wr_load && !shared |=>
		right_applied_code == $past(r.right_gain_reg[CODE_HI:0]))
		else $error("independent right level not kept");
	a_atten_map: assert property (
		1'b1 |=> left_atten_half_db ==
		CODE_FULL_SCALE - $past(left_applied_code) &&
		right_full_mute == ($past(right_applied_code) == CODE_SILENT))
		else $error("attenuation does not follow the applied code");
	a_format_bits: assert property (
		wr_any && link.word[ADDR_HI:ADDR_LO] == SEL_FMT |=>
		shared_gain_select == $past(link.word[FMT_SHARED]) &&
		clock_out_half == $past(link.word[FMT_CLK_HALF]))
		else $error("format word fields misplaced");
	// function word fields land at their fixed positions
	a_func_fields: assert property (
		wr_any && link.word[ADDR_HI:ADDR_LO] == SEL_FUNC |=>
		soft_silence_off == $past(link.word[FN_SILENCE_OFF]) &&
		emphasis_undo_on == $past(link.word[FN_EMPHASIS]) &&
		halved_oversample_sel == $past(link.word[FN_HALVED]) &&
		output_length_code == $past(link.word[FN_OUT_LO+1:FN_OUT_LO]))
		else $error("function word fields misplaced");
	// code 11 picks the longest output word one cycle later
	a_out_longest: assert property (
		output_length_code == 2'h3 |=> output_word_bits == BITS_24)
		else $error("output code 11 did not give 24 bits");
	// the reserved rate code must raise its flag a cycle later
	a_rate_flag: assert property (
		emphasis_rate_code == RATE_RESERVED |=> emphasis_rate_reserved)
		else $error("reserved rate code not flagged");
	// with the frame-format bit set, input codes 10 and 11 give no usable input word
	a_in_reserved: assert property (
		frame_format_i2s && input_format_code[1] |=>
		input_format_reserved && input_word_bits == BITS_NONE)
		else $error("reserved input code not flagged");
endmodule // filter_serial_config_registers
`default_nettype wire

// ==== dv/host_port_model.sv ====
// host-side model writing control words over the three-wire port
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
	input  wire logic clk,    // system clock
	output var  logic strobe, // latch strobe, idle high
	output var  logic sclk,   // bit clock, still outside frames
	output var  logic sdata   // serial data
);
	// idle levels before the first frame
	initial begin
		strobe = 1'b1;
		sclk   = 1'b0;
		sdata  = 1'b0;
	end
	// one word, each level held two cycles so the device sees it
	task automatic send(input logic [15:0] word);
		@(posedge clk) #1 strobe = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdata = word[i];
			repeat (2) @(posedge clk);
			#1 sclk = 1'b1;
			repeat (2) @(posedge clk);
			#1 sclk = 1'b0;
		end
		repeat (2) @(posedge clk);
		#1 strobe = 1'b1;
		sdata = ~sdata; // released line must not keep last bit
		repeat (2) @(posedge clk);
	endtask
endmodule // host_port_model
`default_nettype wire

// ==== dv/filter_serial_config_registers_tb_top.sv ====
// self-checking bench of the serial configuration registers
`timescale 1ns/1ns
`default_nettype none
module filter_serial_config_registers_tb_top;
	import filter_cfg_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, mode_pin = 1'b1; // driven inputs
	logic st, sc, sd;                  // port pins from the host model
	logic [7:0] lc, rc, la, ra;        // applied codes and attenuations
	logic lm, rm, sso, emo, hos, ilj, ifr, rsv, lfh, sgs, srs, coh;
	logic ffi, fsp;                    // frame format and polarity bits
	logic [1:0] ifc, olc;              // raw input and output codes
	logic [4:0] iwb, owb;              // decoded word lengths
	logic [1:0] erc;                   // rate code
	int fails = 0, comparisons = 0;    // result counters
	always #5 clk = ~clk;
	host_port_model host_port_model_i (.clk(clk), .strobe(st),
		.sclk(sc), .sdata(sd));
	filter_serial_config_registers filter_serial_config_registers_i (
		.clk(clk), .resetn(resetn), .mode_pin(mode_pin),
		.latch_strobe_pin(st), .serial_shift_clock_pin(sc),
		.serial_input_pin(sd), .left_applied_code(lc),
		.right_applied_code(rc), .left_atten_half_db(la),
		.right_atten_half_db(ra), .left_full_mute(lm),
		.right_full_mute(rm), .soft_silence_off(sso),
		.emphasis_undo_on(emo), .halved_oversample_sel(hos),
		.input_format_code(ifc), .frame_format_i2s(ffi),
		.input_word_bits(iwb), .input_left_justified(ilj),
		.input_format_reserved(ifr), .output_length_code(olc),
		.output_word_bits(owb), .frame_side_polarity(fsp),
		.left_on_frame_high(lfh), .shared_gain_select(sgs),
		.slow_rolloff_sel(srs), .clock_out_half(coh),
		.emphasis_rate_code(erc), .emphasis_rate_reserved(rsv));
	// compare tasks, one per result width
	task automatic chk8(input logic [7:0] got, exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s %h/%h", $time, m, got, exp);
		end
	endtask
	task automatic chk1(input logic got, exp, input string m);
		chk8({7'h00, got}, {7'h00, exp}, m);
	endtask
	// send a word and let the decoded outputs settle
	task automatic put(input logic [15:0] w);
		host_port_model_i.send(w);
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic complete_run;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_gain;
		put(16'h0080);
		chk8(lc, 8'hFF, "left held");
		put(16'h0240);
		chk8(rc, 8'hFF, "right held");
		put(16'h0340);
		chk8(rc, 8'h40, "right code");
		chk8(lc, 8'h80, "left from stored");
		chk8(ra, 8'hBF, "right atten");
		put(16'h0120);
		chk8(lc, 8'h20, "left code");
		chk8(rc, 8'h40, "right own code");
		$display("test gain done");
	endtask
	task automatic t_shared;
		put(16'h0604);
		chk1(sgs, 1'b1, "shared");
		put(16'h0101);
		chk8(rc, 8'h01, "right shares left");
		chk8(la, 8'hFE, "left atten");
		put(16'h0100);
		chk1(rm, 1'b1, "right mute");
		chk1(lm, 1'b1, "left mute");
		mode_pin = 1'b0;
		put(16'h01AA);
		chk8(lc, 8'h00, "dropped write");
		mode_pin = 1'b1;
		$display("test shared done");
	endtask
	task automatic t_func;
		logic [4:0] ob[4] = '{BITS_16, BITS_18, BITS_20, BITS_24};
		logic [4:0] ib[4] = '{BITS_16, BITS_20, BITS_24, BITS_24};
		for (int k = 0; k < 4; k++) begin
			put(16'h0407 | 16'(k << 5) | 16'(k << 3));
			chk8({3'h0, owb}, {3'h0, ob[k]}, "out bits");
			chk8({3'h0, iwb}, {3'h0, ib[k]}, "in bits");
			chk1(ilj, k == 3, "left justified");
			chk1(sso, 1'b1, "mute off");
			chk1(emo, 1'b1, "emphasis on");
			chk1(hos, 1'b1, "four times");
			chk8({6'h00, olc}, 8'(k), "out code");
			chk8({6'h00, ifc}, 8'(k), "in code");
		end
		put(16'h06CB);
		chk1(lfh, 1'b0, "polarity");
		chk1(srs, 1'b1, "rolloff");
		chk8({6'h00, erc}, 8'h03, "rate");
		chk1(ifr, 1'b1, "i2s reserved");
		chk8({3'h0, iwb}, 8'h00, "reserved bits");
		chk1(ffi & fsp, 1'b1, "frame bits");
		put(16'h0408);
		chk8({3'h0, iwb}, {3'h0, BITS_24}, "i2s 24");
		chk1(ifr, 1'b0, "i2s legal");
		chk8({5'h00, sso, emo, hos}, 8'h00, "func clear");
		put(16'h0660);
		chk1(rsv & coh, 1'b1, "rate reserved");
		$display("test format done");
	endtask
	// watchdog far beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 resetn = 1'b1;
		chk8(lc, 8'hFF, "reset left");
		chk8(la, 8'h00, "reset atten");
		chk1(sso, 1'b0, "reset soft mute on");
		chk1(lfh, 1'b1, "reset polarity");
		t_gain();
		t_shared();
		t_func();
		complete_run();
	end
endmodule // filter_serial_config_registers_tb_top
`default_nettype wire
